// ---- sw_model.sv ----
`timescale 1ns/1ps
// Software side: one write per strobe, data lines inverted when idle
module sw_model
(
  input  wire       clk_in,
  output reg        ta_wr_out,
  output reg  [7:0] ta_data_out,
  output reg        ctl_wr_out,
  output reg  [7:0] ctl_data_out
);
  initial
  begin
    {ta_wr_out, ta_data_out, ctl_wr_out, ctl_data_out} = 18'h00000;
  end
  task ta_write(input [7:0] d);
  begin
    @(posedge clk_in) {ta_wr_out, ta_data_out} <= {1'b1, d};
    @(posedge clk_in) {ta_wr_out, ta_data_out} <= {1'b0, ~d};
  end
  endtask
  task ctl_write(input [7:0] d);
  begin
    @(posedge clk_in) {ctl_wr_out, ctl_data_out} <= {1'b1, d};
    @(posedge clk_in) {ctl_wr_out, ctl_data_out} <= {1'b0, ~d};
  end
  endtask
  // Gap of idle clocks lets a slow writer miss the window
  task prot_write(input [7:0] d, input integer gap);
  begin
    ta_write(8'hAA);
    ta_write(8'h55);
    repeat (gap) @(posedge clk_in);
    ctl_write(d);
  end
  endtask
endmodule // sw_model

// ---- timed_access.v ----
`timescale 1ns/1ps
`include "wdog_defines.vh"
// Opens a short write window after the two-key sequence
module timed_access
(
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       ta_wr_in,
  input  wire [7:0] ta_data_in,
  input  wire       prot_wr_in,
  output wire       open_out
);
  reg       key1_r;
  reg [1:0] win_r;

  assign open_out = (win_r != 2'h0);

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key1_r <= 1'b0;
      win_r  <= 2'h0;
    end
    else
    begin
      if (ta_wr_in)
      begin
        key1_r <= (ta_data_in == `TA_KEY1);
        if (key1_r && ta_data_in == `TA_KEY2)
          win_r <= `TA_WINDOW;
        else
          win_r <= 2'h0;
      end
      else if (prot_wr_in && open_out)
        win_r <= 2'h0;
      else if (open_out)
        win_r <= win_r - 2'h1;
    end
  end
endmodule // timed_access

// ---- watchdog_and_reset_supervisor.v ----
`timescale 1ns/1ps
`include "wdog_defines.vh"
module watchdog_and_reset_supervisor
#(
  parameter [16:0] LONG_RESET_CLKS = `RST_LONG_CLKS
)
(
  input  wire       clk_in,
  input  wire       rst_n_in,
  input  wire       supply_low_in,
  input  wire       supply_warn_in,
  input  wire       osc_fail_in,
  input  wire       ext_reset_in,
  input  wire       ta_wr_in,
  input  wire [7:0] ta_data_in,
  input  wire       ctl_wr_in,
  input  wire [7:0] ctl_data_in,
  input  wire       flag_clr_in,
  input  wire [1:0] timeout_sel_in,
  input  wire       clock_multiplier_sel_in,
  input  wire [1:0] clock_divide_sel_in,
  input  wire       wdog_irq_enable_in,
  output reg  [7:0] wdog_control_reg_out,
  output reg        wdog_irq_out,
  output reg        supply_warning_irq_out,
  output reg  [15:0] irq_vector_out,
  output reg        cpu_reset_out,
  output reg        reset_out_n,
  output reg  [15:0] start_addr_out
);
  // ****************************************
  // Control byte bit positions
  // ****************************************
  localparam POR_BIT = 6;
  localparam PFW_EN_BIT = 5;
  localparam PFW_FLAG_BIT = 4;
  localparam WIF_BIT = 3;
  localparam WRF_BIT = 2;
  localparam WRE_BIT = 1;
  localparam RESTART_BIT = 0;

  localparam ST_RUN = 2'h0;
  localparam ST_LONG = 2'h1;
  localparam ST_SHORT = 2'h2;

  reg  [34:0] wd_cnt_r;
  reg  [9:0]  gap_cnt_r;
  reg         gap_run_r;
  reg         wdog_irq_flag_r;
  reg         wdog_reset_flag_r;
  reg         wdog_reset_enable_r;
  reg         supply_warning_enable_r;
  reg         supply_warning_flag_r;
  reg         por_flag_r;
  reg  [1:0]  state_r;
  reg  [16:0] rst_cnt_r;
  wire        ta_open;
  wire        prot_wr;
  wire [5:0]  tmo_exp;
  wire        wd_tick;
  wire        wd_restart;
  wire        wd_fire;

  // ****************************************
  // Timeout exponent
  // ****************************************
  function [5:0] base_exp;
    input       mult4x;
    input [1:0] div;
    begin
      if (div == `CLK_DIV_11)
        base_exp = `WDOG_BASE_SLOW;
      else if (div != `CLK_DIV_00)
        base_exp = `WDOG_BASE_MID;
      else if (mult4x)
        base_exp = `WDOG_BASE_4X;
      else
        base_exp = `WDOG_BASE_2X;
    end
  endfunction

  assign tmo_exp = base_exp(clock_multiplier_sel_in, clock_divide_sel_in)
                   + {3'h0, timeout_sel_in, 1'b0} + {4'h0, timeout_sel_in};

  // Counter reaches all ones below the selected bit; compare against that all-ones mask gives one tick per 2^exp clocks
  assign wd_tick    = (wd_cnt_r == ((35'h1 << tmo_exp) - 35'h1));
  assign prot_wr    = ctl_wr_in && ta_open;
  assign wd_restart = prot_wr && ctl_data_in[RESTART_BIT];
  assign wd_fire    = gap_run_r && (gap_cnt_r == `WDOG_RESET_GAP - 10'h1);

  timed_access u_ta
  (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .ta_wr_in   (ta_wr_in),
    .ta_data_in (ta_data_in),
    .prot_wr_in (ctl_wr_in),
    .open_out   (ta_open)
  );

  // ****************************************
  // Watchdog counter and flags
  // ****************************************
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wd_cnt_r <= 35'h0;
      gap_cnt_r <= 10'h0;
      gap_run_r <= 1'b0;
      wdog_irq_flag_r <= 1'b0;
      wdog_reset_flag_r <= 1'b0;
      wdog_reset_enable_r <= 1'b0;
      supply_warning_enable_r <= 1'b0;
      supply_warning_flag_r <= 1'b0;
      por_flag_r <= 1'b1;
    end
    else if (cpu_reset_out)
    begin
      // Processor reset clears control but keeps reset-cause flags
      wd_cnt_r <= 35'h0;
      gap_cnt_r <= 10'h0;
      gap_run_r <= 1'b0;
      wdog_irq_flag_r <= 1'b0;
      wdog_reset_enable_r <= 1'b0;
      supply_warning_enable_r <= 1'b0;
      if (state_r == ST_LONG && supply_low_in)
        por_flag_r <= 1'b1;
    end
    else
    begin
      if (wd_restart)
      begin
        wd_cnt_r <= 35'h0;
        gap_run_r <= 1'b0;
        gap_cnt_r <= 10'h0;
      end
      else if (wd_tick)
      begin
        wd_cnt_r <= 35'h0;
        gap_run_r <= 1'b1;
        gap_cnt_r <= 10'h0;
      end
      else
      begin
        wd_cnt_r <= wd_cnt_r + 35'h1;
        if (wd_fire)
          gap_run_r <= 1'b0;
        else if (gap_run_r)
          gap_cnt_r <= gap_cnt_r + 10'h1;
      end
      if (prot_wr)
        wdog_reset_enable_r <= ctl_data_in[WRE_BIT];
      if (ctl_wr_in)
        supply_warning_enable_r <= ctl_data_in[PFW_EN_BIT];
      // Set beats clear; flags clear by software writing zero, but the reset flag clears on flag_clr_in
      if (wd_tick && !wd_restart)
        wdog_irq_flag_r <= 1'b1;
      else if (prot_wr && !ctl_data_in[WIF_BIT])
        wdog_irq_flag_r <= 1'b0;
      if (wd_fire && !wd_restart)
        wdog_reset_flag_r <= 1'b1;
      else if (flag_clr_in)
        wdog_reset_flag_r <= 1'b0;
      if (supply_warn_in)
        supply_warning_flag_r <= 1'b1;
      else if (ctl_wr_in && !ctl_data_in[PFW_FLAG_BIT])
        supply_warning_flag_r <= 1'b0;
      if (prot_wr && !ctl_data_in[POR_BIT])
        por_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Reset sequencer
  // ****************************************
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_LONG;
      rst_cnt_r <= 17'h0;
      cpu_reset_out <= 1'b1;
      reset_out_n <= 1'b0;
      start_addr_out <= `VEC_RESET;
    end
    else
    begin
      start_addr_out <= `VEC_RESET;
      case (state_r)
        ST_RUN:
        begin
          if (supply_low_in || osc_fail_in)
          begin
            state_r <= ST_LONG;
            rst_cnt_r <= 17'h0;
            cpu_reset_out <= 1'b1;
            reset_out_n <= 1'b0;
          end
          else if (wd_fire && !wd_restart && wdog_reset_enable_r)
          begin
            state_r <= ST_SHORT;
            rst_cnt_r <= `RST_WDOG_CLKS - 17'h1;
            cpu_reset_out <= 1'b1;
            reset_out_n <= 1'b0;
          end
          else if (ext_reset_in)
          begin
            state_r <= ST_SHORT;
            rst_cnt_r <= `RST_EXT_CLKS - 17'h1;
            cpu_reset_out <= 1'b1;
            reset_out_n <= 1'b0;
          end
        end
        ST_LONG:
        begin
          // Supply low restarts the full count on recovery
          if (supply_low_in || osc_fail_in)
            rst_cnt_r <= 17'h0;
          else if (rst_cnt_r == LONG_RESET_CLKS - 17'h1)
          begin
            state_r <= ST_RUN;
            cpu_reset_out <= 1'b0;
            reset_out_n <= 1'b1;
          end
          else
            rst_cnt_r <= rst_cnt_r + 17'h1;
        end
        ST_SHORT:
        begin
          if (supply_low_in || osc_fail_in)
          begin
            state_r <= ST_LONG;
            rst_cnt_r <= 17'h0;
          end
          else if (rst_cnt_r == 17'h0)
          begin
            // External reset is held while its input stays high
            if (!ext_reset_in)
            begin
              state_r <= ST_RUN;
              cpu_reset_out <= 1'b0;
              reset_out_n <= 1'b1;
            end
          end
          else
            rst_cnt_r <= rst_cnt_r - 17'h1;
        end
        default:
          state_r <= ST_LONG;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wdog_control_reg_out <= 8'h00;
      wdog_irq_out <= 1'b0;
      supply_warning_irq_out <= 1'b0;
      irq_vector_out <= `VEC_RESET;
    end
    else
    begin
      wdog_control_reg_out <= {1'b0, por_flag_r, supply_warning_enable_r, supply_warning_flag_r,
                               wdog_irq_flag_r, wdog_reset_flag_r, wdog_reset_enable_r, 1'b0};
      wdog_irq_out <= wdog_irq_flag_r && wdog_irq_enable_in;
      supply_warning_irq_out <= supply_warning_flag_r && supply_warning_enable_r;
      irq_vector_out <= `VEC_SUPPLY_WARN;
    end
  end
endmodule // watchdog_and_reset_supervisor

// ---- watchdog_and_reset_supervisor_tb.sv ----
`timescale 1ns/1ps
module watchdog_and_reset_supervisor_tb;
  reg         clk_in, rst_n_in, s_low, s_warn, osc, ext, f_clr, mult, irq_en;
  reg  [1:0]  sel, div;
  wire        ta_wr, ctl_wr, irq, w_irq, cpu_rst, rst_n_out;
  wire [7:0]  ta_d, ctl_d, st;
  wire [15:0] vec, start;
  integer     n_mismatch = 0, checks = 0, cyc = 0, n;
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  sw_model u_sw_model (.clk_in(clk_in), .ta_wr_out(ta_wr), .ta_data_out(ta_d), .ctl_wr_out(ctl_wr),
    .ctl_data_out(ctl_d));
  watchdog_and_reset_supervisor #(.LONG_RESET_CLKS(17'h00040)) u_watchdog_and_reset_supervisor (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .supply_low_in(s_low), .supply_warn_in(s_warn), .osc_fail_in(osc), .ext_reset_in(ext),
    .ta_wr_in(ta_wr), .ta_data_in(ta_d), .ctl_wr_in(ctl_wr), .ctl_data_in(ctl_d), .flag_clr_in(f_clr),
    .timeout_sel_in(sel), .clock_multiplier_sel_in(mult), .clock_divide_sel_in(div),
    .wdog_irq_enable_in(irq_en), .wdog_control_reg_out(st), .wdog_irq_out(irq), .supply_warning_irq_out(w_irq),
    .irq_vector_out(vec), .cpu_reset_out(cpu_rst), .reset_out_n(rst_n_out), .start_addr_out(start));
  // ****************
  // Helpers
  // ****************
  function [31:0] f_tmo(input m, input [1:0] d, input [1:0] s);
  begin
    f_tmo = 32'h1 << ((d == 2'h3 ? 6'h19 : d != 2'h0 ? 6'h11 : m ? 6'h0F : 6'h10) + 6'h03 * s);
  end
  endfunction
  task check(input [127:0] name, input [31:0] exp, input [31:0] tol, input [31:0] got);
  begin
    checks = checks + 1;
    if ((^got) === 1'bx || got + tol < exp || got > exp + tol)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0s expected %0h seen %0h", name, exp, got);
    end
  end
  endtask
  task tick(input integer k);
  begin
    repeat (k) @(posedge clk_in);
    #1;
  end
  endtask
  // Waits up to 600 clocks for the fall, then counts low clocks
  task low_len(output integer len);
  begin
    len = 0;
    #1;
    for (n = 0; n < 600 && rst_n_out !== 1'b0; n = n + 1) tick(1);
    while (rst_n_out === 1'b0 && len < 1000) begin tick(1); len = len + 1; end
  end
  endtask
  task final_report;
  begin
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end
  endtask
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin n_mismatch = n_mismatch + 1; final_report; end
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    {rst_n_in, s_low, s_warn, osc, ext, f_clr, irq_en, sel, div} = 11'h000;
    mult = 1'b1;
    n = $urandom(32'h93659E56);
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    low_len(n); check("power on pulse", 64, 0, n);
    check("start addr", 16'h0000, 0, start);
    check("por flag", 1, 0, st[6]);
    u_sw_model.ctl_write(8'h02); tick(2); check("open write", 8'h40, 0, st & 8'h43);
    u_sw_model.prot_write(8'h02, 3); tick(2); check("late window", 0, 0, st[1]);
    u_sw_model.prot_write(8'h00, 0); tick(2); check("por clear", 0, 0, st[6]);
    repeat (4) begin u_sw_model.ctl_write($urandom & 8'hCB); tick(2); check("random open", 0, 0, st & 8'h4B); end
    u_sw_model.ctl_write(8'h20);
    @(posedge clk_in) s_warn <= 1'b1;
    @(posedge clk_in) s_warn <= 1'b0;
    tick(2); check("warn flag", 3, 0, st[5:4]); check("warn irq", 16'h0033, 0, w_irq ? vec : 16'hFFFF);
    u_sw_model.ctl_write(8'h20); tick(2); check("warn clear", 2, 0, st[5:4]);
    @(posedge clk_in) irq_en <= 1'b1;
    u_sw_model.prot_write(8'h01, 0);
    // Status lags one clock; step past the write edge before counting
    tick(1);
    for (n = 0; n < 40000 && st[3] !== 1'b1; n = n + 1) tick(1);
    check("irq time", f_tmo(1'b1, 2'h0, 2'h0), 0, n); check("wdog irq", 1, 0, irq);
    low_len(n); check("no wdog reset", 0, 0, n); check("reset flag", 1, 0, st[2]);
    @(posedge clk_in) {f_clr, irq_en} <= 2'b10;
    @(posedge clk_in) f_clr <= 1'b0;
    u_sw_model.prot_write(8'h03, 0);
    // Old flag still shows at the write edge; wait for the cleared status
    tick(1); check("irq flag clear", 0, 0, st[3]);
    for (n = 0; n < 40000 && st[3] !== 1'b1; n = n + 1) tick(1);
    check("irq time 2", f_tmo(1'b1, 2'h0, 2'h0), 0, n); check("irq masked", 0, 0, irq);
    low_len(n); check("wdog pulse", 8, 0, n);
    @(posedge clk_in) ext <= 1'b1;
    @(posedge clk_in) ext <= 1'b0;
    low_len(n); check("ext pulse", 4, 0, n);
    @(posedge clk_in) s_low <= 1'b1;
    tick(6); check("supply hold", 1, 0, cpu_rst);
    @(posedge clk_in) s_low <= 1'b0;
    low_len(n); check("supply pulse", 64, 0, n); check("por again", 1, 0, st[6]);
    @(posedge clk_in) osc <= 1'b1;
    @(posedge clk_in) osc <= 1'b0;
    low_len(n); check("osc pulse", 64, 0, n);
    final_report;
  end
endmodule // watchdog_and_reset_supervisor_tb

// ---- wdog_defines.vh ----
`ifndef WDOG_DEFINES_VH
`define WDOG_DEFINES_VH
// Timed-access key values
`define TA_KEY1           8'hAA
`define TA_KEY2           8'h55
// Timed-access window length in clocks
`define TA_WINDOW         2'h3
// Gap between interrupt flag and reset flag
`define WDOG_RESET_GAP    10'h200
// Timeout exponent bases
`define WDOG_BASE_4X      6'h0F
`define WDOG_BASE_2X      6'h10
`define WDOG_BASE_MID     6'h11
`define WDOG_BASE_SLOW    6'h19
// Divider codes
`define CLK_DIV_00        2'h0
`define CLK_DIV_11        2'h3
// Reset output pulse lengths in clocks
`define RST_LONG_CLKS     17'h10000
`define MACHINE_CYCLE     17'h4
`define RST_WDOG_CLKS     17'h8
`define RST_EXT_CLKS      17'h4
// Reset and interrupt vectors
`define VEC_RESET         16'h0000
`define VEC_SUPPLY_WARN   16'h0033
`endif

// ---- wdog_props.sv ----
`timescale 1ns/1ps
module wdog_props
(
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        supply_low_in,
  input wire        supply_warn_in,
  input wire        ext_reset_in,
  input wire        wdog_irq_enable_in,
  input wire [7:0]  wdog_control_reg_out,
  input wire        wdog_irq_out,
  input wire        supply_warning_irq_out,
  input wire [15:0] irq_vector_out,
  input wire        cpu_reset_out,
  input wire        reset_out_n,
  input wire [15:0] start_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_restart_reads_zero: assert property (wdog_control_reg_out[0] == 1'b0)
    else $error("restart bit read as one");
  chk_reset_flag_gap: assert property ($rose(wdog_control_reg_out[3]) |-> ##[512:512] $rose(wdog_control_reg_out[2]))
    else $error("reset flag not 512 clocks after irq flag");
  chk_supply_low_hold: assert property (supply_low_in ##1 supply_low_in |-> cpu_reset_out && !reset_out_n)
    else $error("supply low without reset");
  chk_warn_flag_set: assert property (supply_warn_in |-> ##[1:2] wdog_control_reg_out[4])
    else $error("warning flag not set");
  chk_warn_irq_raise: assert property (supply_warn_in && wdog_control_reg_out[5] |-> ##[1:2] supply_warning_irq_out)
    else $error("warning irq missing");
  chk_warn_vector_value: assert property (supply_warning_irq_out |-> irq_vector_out == 16'h0033)
    else $error("warning vector wrong");
  chk_start_addr_zero: assert property (start_addr_out == 16'h0000)
    else $error("start address not zero");
  chk_ext_reset_drive: assert property (ext_reset_in |-> ##[0:2] !reset_out_n)
    else $error("external reset not driven");
  chk_irq_enable_gate: assert property (!wdog_irq_enable_in ##1 !wdog_irq_enable_in |-> !wdog_irq_out)
    else $error("watchdog irq while disabled");
endmodule // wdog_props
bind watchdog_and_reset_supervisor wdog_props u_wdog_props (.clk_in, .rst_n_in, .supply_low_in, .supply_warn_in,
  .ext_reset_in, .wdog_irq_enable_in, .wdog_control_reg_out, .wdog_irq_out, .supply_warning_irq_out,
  .irq_vector_out, .cpu_reset_out, .reset_out_n, .start_addr_out);
